// >>> hw/cfr_top.sv
`timescale 1ns/1ps
module cfr_top (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [cfr_pkg::DW-1:0] sample_in,
    input wire logic fill_trig_in,
    input wire logic dump_req_in,
    input wire logic [7:0] capture_length_code_in,
    input wire logic [1:0] fill_mode_in,
    input wire logic [1:0] out_sel_in,
    input wire logic [5:0] decim_ratio_in,
    input wire logic serial_leader_in,
    input wire logic serial_port_clock_in,
    input wire logic serial_frame_sync_in,
    output logic full_out,
    output logic empty_out,
    output logic [cfr_pkg::DW-1:0] parallel_word_bus_out,
    output logic parallel_clk_out,
    output logic [cfr_pkg::HW-1:0] ddr_data_out,
    output logic ddr_clk_out,
    output logic serial_port_clock_out,
    output logic serial_port_clock_oe_out,
    output logic serial_frame_sync_out,
    output logic serial_frame_sync_oe_out,
    output logic serial_data_out
);
    import cfr_pkg::*;
    logic [DW-1:0] mem [DEPTH];
    cfr_state_t st_q, st_d;
    logic [CW-1:0] fcnt_q, fcnt_d, nsamp, rreq_q, rreq_d, wout_q, wout_d;
    logic [AW-1:0] wp_q, wp_d, rbase_q, rbase_d, ra_q, ra_d, wa;
    logic [6:0] dcnt_q, dcnt_d, start;
    logic [5:0] ph_q, ph_d, ratio, half;
    logic [3:0] bit_q, bit_d, ecnt_q, ecnt_d;
    logic [1:0] lead_q, lead_d;
    logic [DW-1:0] word_q, word_d, rd_q, par_q, par_d, out_word;
    logic [HW-1:0] ddr_q, ddr_d;
    logic full_q, full_d, empty_q, empty_d, run_q, run_d, fin_q, fin_d;
    logic rdv_q, rdv_d, pclk_q, pclk_d, dclk_q, dclk_d, sclk_q, sclk_d;
    logic fs_q, fs_d, sd_q, sd_d, soe_q, soe_d, sin_q;
    logic wr_en, rd_en, in_rdy, out_vld, pop;
    logic ser, par_if, ddr_if, lead_mode, rise, fall, fol, tick, lastw;

    assign full_out = full_q;
    assign empty_out = empty_q;
    assign parallel_word_bus_out = par_q;
    assign parallel_clk_out = pclk_q;
    assign ddr_data_out = ddr_q;
    assign ddr_clk_out = dclk_q;
    assign serial_port_clock_out = sclk_q;
    assign serial_port_clock_oe_out = soe_q;
    assign serial_frame_sync_out = fs_q;
    assign serial_frame_sync_oe_out = soe_q;
    assign serial_data_out = sd_q;

    always_comb begin
        nsamp = cfr_samples(capture_length_code_in);
        ratio = cfr_decim(decim_ratio_in);
        half = ratio >> 1;
        ser = out_sel_in == SEL_SER;
        par_if = out_sel_in == SEL_PAR;
        ddr_if = out_sel_in == SEL_DDR;
        lead_mode = !ser || serial_leader_in;
        start = ser ? SER_START : PAR_START;
        rise = run_q && ph_q == '0;
        fall = run_q && ph_q == half;
        // Follower clock is a synchronous input; edge found against last cycle
        fol = ser && !serial_leader_in && st_q == ST_DUMP
            && serial_port_clock_in && !sin_q;
        tick = lead_mode ? fall : fol;
        lastw = wout_q == nsamp;
        pop = tick && lead_q == '0 && bit_q == '0 && !lastw && out_vld
            && !fin_q;
        wa = (st_q == ST_CONT) ? wp_q : fcnt_q[AW-1:0];
    end

    // Capture sequencer
    always_comb begin
        st_d = st_q;
        fcnt_d = fcnt_q;
        wp_d = wp_q;
        rbase_d = rbase_q;
        dcnt_d = dcnt_q;
        ecnt_d = ecnt_q;
        full_d = full_q;
        empty_d = empty_q;
        wr_en = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (fill_mode_in == MODE_CONT) begin
                    st_d = ST_CONT;
                end else if (fill_trig_in) begin
                    st_d = ST_FILL;
                    fcnt_d = '0;
                    rbase_d = '0;
                end
            end
            ST_FILL: begin
                if (fill_trig_in) begin
                    fcnt_d = '0;
                end else begin
                    fcnt_d = fcnt_q + 1'b1;
                    wr_en = fcnt_q < nsamp;
                    if (fcnt_q == EMPTY_DLY - 1'b1) begin
                        empty_d = 1'b0;
                    end
                    if (fcnt_q == nsamp + FULL_XTRA - 1'b1) begin
                        full_d = 1'b1;
                        st_d = ST_FULL;
                    end
                end
            end
            ST_CONT: begin
                // History is only complete once nsamp samples have been written
                wr_en = 1'b1;
                wp_d = wp_q + 1'b1;
                empty_d = 1'b0;
                if (fill_trig_in) begin
                    st_d = ST_STOP;
                    fcnt_d = '0;
                    rbase_d = wp_q + 1'b1 - nsamp[AW-1:0];
                end else if (fill_mode_in != MODE_CONT) begin
                    st_d = ST_IDLE;
                end
            end
            ST_STOP: begin
                fcnt_d = fcnt_q + 1'b1;
                if (fcnt_q == FULL_XTRA - 1'b1) begin
                    full_d = 1'b1;
                    st_d = ST_FULL;
                end
            end
            ST_FULL: begin
                if (dump_req_in) begin
                    st_d = ST_DUMP;
                    dcnt_d = '0;
                    full_d = 1'b0;
                end
            end
            ST_DUMP: begin
                if (dcnt_q != start) begin
                    dcnt_d = dcnt_q + 1'b1;
                end
                if (fin_q && (lead_mode ? rise : fol)) begin
                    st_d = ST_DONE;
                    ecnt_d = '0;
                end
            end
            ST_DONE: begin
                ecnt_d = ecnt_q + 1'b1;
                if (ecnt_q == EMPTY_RISE - 1'b1) begin
                    empty_d = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= ST_IDLE;
            fcnt_q <= '0;
            wp_q <= '0;
            rbase_q <= '0;
            dcnt_q <= '0;
            ecnt_q <= '0;
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            st_q <= st_d;
            fcnt_q <= fcnt_d;
            wp_q <= wp_d;
            rbase_q <= rbase_d;
            dcnt_q <= dcnt_d;
            ecnt_q <= ecnt_d;
            full_q <= full_d;
            empty_q <= empty_d;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (wr_en) begin
            mem[wa] <= sample_in;
        end
        if (rd_en) begin
            rd_q <= mem[ra_q];
        end
    end

    // Readout: one read in flight, so the buffer never overflows
    cfr_skid #(
        .W(DW),
        .DEPTH(SKID_DEPTH)
    ) u_buf (
        .clk_in(core_clk_in),
        .rst_in(rst_in),
        .in_valid_in(rdv_q),
        .in_ready_out(in_rdy),
        .in_data_in(rd_q),
        .out_valid_out(out_vld),
        .out_ready_in(pop),
        .out_data_out(out_word)
    );

    always_comb begin
        ra_d = ra_q;
        rreq_d = rreq_q;
        wout_d = wout_q;
        lead_d = lead_q;
        bit_d = bit_q;
        word_d = word_q;
        fin_d = fin_q;
        run_d = run_q;
        ph_d = ph_q;
        rd_en = 1'b0;
        rdv_d = rdv_q && !in_rdy;
        par_d = par_q;
        ddr_d = ddr_q;
        sd_d = sd_q;
        fs_d = fs_q;
        if (st_q == ST_FULL) begin
            ra_d = rbase_q;
            rreq_d = '0;
            wout_d = '0;
            lead_d = ser ? LEAD_SER : LEAD_PAR;
            bit_d = '0;
            fin_d = 1'b0;
        end else if (st_q == ST_DUMP) begin
            rd_en = in_rdy && !rdv_q && rreq_q != nsamp;
            if (rd_en) begin
                ra_d = ra_q + 1'b1;
                rreq_d = rreq_q + 1'b1;
                rdv_d = 1'b1;
            end
            if (tick && lead_q != '0) begin
                if (lead_mode || serial_frame_sync_in) begin
                    lead_d = lead_q - 1'b1;
                end
            end else if (pop) begin
                word_d = out_word;
                wout_d = wout_q + 1'b1;
                bit_d = ser ? MSB_BIT : '0;
                if (!ser && wout_d == nsamp) begin
                    fin_d = 1'b1;
                end
            end else if (tick && bit_q != '0) begin
                bit_d = bit_q - 1'b1;
                if (bit_q == 4'h1 && lastw) begin
                    fin_d = 1'b1;
                end
            end
            if (!run_q && !fin_q && lead_mode && dcnt_q == start) begin
                run_d = 1'b1;
                ph_d = '0;
            end
        end
        if (run_q) begin
            ph_d = (ph_q == ratio - 1'b1) ? '0 : ph_q + 1'b1;
            if (fin_q && fall) begin
                run_d = 1'b0;
            end
        end
        if (pop && par_if) begin
            par_d = out_word;
        end
        if (ddr_if && pop) begin
            ddr_d = out_word[DW-1:HW];
        end else if (ddr_if && rise) begin
            ddr_d = word_q[HW-1:0];
        end
        if (ser && pop) begin
            sd_d = out_word[MSB_BIT];
        end else if (ser && tick && bit_q != '0) begin
            sd_d = word_q[bit_q - 1'b1];
        end
        if (tick) begin
            fs_d = ser && serial_leader_in && lead_q != '0;
        end
        pclk_d = par_if && run_q && ph_q < half;
        dclk_d = ddr_if && run_q && ph_q < half;
        sclk_d = ser && serial_leader_in && run_q && ph_q < half;
        soe_d = ser && serial_leader_in;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ra_q <= '0;
            rreq_q <= '0;
            wout_q <= '0;
            lead_q <= '0;
            bit_q <= '0;
            word_q <= '0;
            fin_q <= 1'b0;
            run_q <= 1'b0;
            ph_q <= '0;
            rdv_q <= 1'b0;
            par_q <= '0;
            ddr_q <= '0;
            sd_q <= 1'b0;
            fs_q <= 1'b0;
            pclk_q <= 1'b0;
            dclk_q <= 1'b0;
            sclk_q <= 1'b0;
            soe_q <= 1'b0;
            sin_q <= 1'b0;
        end else begin
            ra_q <= ra_d;
            rreq_q <= rreq_d;
            wout_q <= wout_d;
            lead_q <= lead_d;
            bit_q <= bit_d;
            word_q <= word_d;
            fin_q <= fin_d;
            run_q <= run_d;
            ph_q <= ph_d;
            rdv_q <= rdv_d;
            par_q <= par_d;
            ddr_q <= ddr_d;
            sd_q <= sd_d;
            fs_q <= fs_d;
            pclk_q <= pclk_d;
            dclk_q <= dclk_d;
            sclk_q <= sclk_d;
            soe_q <= soe_d;
            sin_q <= serial_port_clock_in;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    empty_fall_a: assert property (
        st_q == ST_FILL && !fill_trig_in && fcnt_q == EMPTY_DLY - 1'b1
        |=> !empty_out) else $error("empty not low after trigger");
    no_overfill_a: assert property (
        st_q == ST_FILL && fcnt_q >= nsamp |-> !wr_en)
        else $error("sample stored past capture length");
    full_time_a: assert property (
        $rose(full_out) && $past(st_q) == ST_FILL
        |-> $past(fcnt_q) == nsamp + FULL_XTRA - 1'b1)
        else $error("full rose at wrong count");
    pclk_start_a: assert property (
        st_q == ST_DUMP && par_if && !run_q && !fin_q && dcnt_q == start
        |-> ##2 parallel_clk_out) else $error("word clock late");
    pclk_park_a: assert property (
        st_q == ST_FULL |-> !parallel_clk_out && !run_q)
        else $error("word clock not parked low");
    pclk_rate_a: assert property (
        $rose(parallel_clk_out) |=> !$rose(parallel_clk_out) [*7])
        else $error("word clock faster than clk/8");
    empty_rise_a: assert property (
        $rose(st_q == ST_DONE) |-> ##1 !empty_out [*8] ##1 empty_out)
        else $error("empty rise not nine cycles after last edge");
    one_port_a: assert property (
        $onehot0({parallel_clk_out, ddr_clk_out, serial_port_clock_oe_out}))
        else $error("more than one output interface active");
    follower_quiet_a: assert property (
        !serial_port_clock_oe_out
        |-> !serial_port_clock_out && !serial_frame_sync_out)
        else $error("serial pins driven as follower");
    fs_width_a: assert property (
        $rose(serial_frame_sync_out) |=> serial_frame_sync_out [*7])
        else $error("frame sync shorter than a serial clock");
    word_count_a: assert property (
        $rose(st_q == ST_DONE) |-> wout_q == nsamp)
        else $error("readout word count wrong");

    full_seen_c: cover property ($rose(full_out));
    dump_done_c: cover property ($rose(st_q == ST_DONE) && par_if);
    cont_stop_c: cover property (st_q == ST_CONT ##1 st_q == ST_STOP);
    serial_run_c: cover property ($fell(serial_frame_sync_out) && ser);
endmodule

// >>> common/cfr_pkg.sv
// What this block does
// - Empty drops 24 cycles after the trigger was last seen high; in fill mode 01 it drops as soon as continuous loading starts.
// - Store (capture_length_code + 1) x 64 samples, then flag full.
// - Full rises (code + 1) x 64 + 13 cycles after trigger last high; in fill mode 01 it rises 13 cycles after the trigger.
// - Parallel word clock starts 73 cycles after dump seen high.
// - Word clock parks low after the last word until next dump.
// - 12-bit words at most clock/8; first after two word clocks.
// - Empty rises nine cycles after the final word clock rise.
// - Fill mode 01 loads continuously; trigger stops it, keeps history.
// - Only one output interface is active, chosen before readout.
// - Serial clock and frame sync driven as leader, inputs as follower.
// - Leader frame sync lasts one serial clock, then data shifts.
// - DDR output sends each sample as upper then lower half.
// - Word clock divides sample clock by even ratio 8 to 32.
// - New trigger during capture restarts counting; counts once low.
package cfr_pkg;
    localparam int DW = 12;
    localparam int HW = 6;
    localparam int AW = 14;
    localparam int DEPTH = 16384;
    localparam int CW = 15;
    localparam int SKID_DEPTH = 2;
    localparam logic [CW-1:0] CHUNK = 15'h0040;
    localparam logic [CW-1:0] EMPTY_DLY = 15'h0018;
    localparam logic [CW-1:0] FULL_XTRA = 15'h000d;
    localparam logic [6:0] PAR_START = 7'h47;
    localparam logic [6:0] SER_START = 7'h05;
    localparam logic [3:0] EMPTY_RISE = 4'h9;
    localparam logic [5:0] DEC_MIN = 6'h08;
    localparam logic [5:0] DEC_MAX = 6'h20;
    localparam logic [5:0] ODD_BIT = 6'h01;
    localparam logic [1:0] LEAD_PAR = 2'h2;
    localparam logic [1:0] LEAD_SER = 2'h1;
    localparam logic [3:0] MSB_BIT = 4'hb;
    localparam logic [1:0] MODE_CONT = 2'h1;
    localparam logic [1:0] SEL_PAR = 2'h0;
    localparam logic [1:0] SEL_DDR = 2'h1;
    localparam logic [1:0] SEL_SER = 2'h2;
    localparam logic [1:0] SEL_SPI = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FILL = 3'h1,
        ST_FULL = 3'h3,
        ST_DUMP = 3'h2,
        ST_DONE = 3'h6,
        ST_CONT = 3'h4,
        ST_STOP = 3'h5
    } cfr_state_t;

    function automatic logic [CW-1:0] cfr_samples(input logic [7:0] code);
        return ({7'h00, code} + 15'h0001) * CHUNK;
    endfunction

    // Out-of-range ratios are clamped so the word clock stays <= clk/8
    function automatic logic [5:0] cfr_decim(input logic [5:0] r);
        logic [5:0] v;
        v = r;
        if (r < DEC_MIN) begin
            v = DEC_MIN;
        end else if (r > DEC_MAX) begin
            v = DEC_MAX;
        end
        return v & ~ODD_BIT;
    endfunction
endpackage

// >>> hw/cfr_skid.sv
`timescale 1ns/1ps
module cfr_skid #(
    parameter int W = 12,
    parameter int DEPTH = 2
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULLC = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LASTP = PW'(DEPTH - 1);
    logic [W-1:0] buf_q [DEPTH];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [PW:0] cnt_q, cnt_d;
    logic push, pull;

    assign in_ready_out = cnt_q != FULLC;
    assign out_valid_out = cnt_q != '0;
    assign out_data_out = buf_q[rp_q];

    always_comb begin
        push = in_valid_in && in_ready_out;
        pull = out_valid_out && out_ready_in;
        wp_d = wp_q;
        rp_d = rp_q;
        if (push) begin
            wp_d = (wp_q == LASTP) ? '0 : wp_q + 1'b1;
        end
        if (pull) begin
            rp_d = (rp_q == LASTP) ? '0 : rp_q + 1'b1;
        end
        cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pull};
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage needs no reset; count gates every read
    always_ff @(posedge clk_in) begin
        if (push) begin
            buf_q[wp_q] <= in_data_in;
        end
    end
endmodule

// >>> bench/cfr_host.sv
`timescale 1ns/1ps
module cfr_host (
    input wire logic clk_in,
    input wire logic full_in,
    input wire logic empty_in,
    input wire logic follow_in,
    output logic trig_out,
    output logic dump_out,
    output logic sclk_out,
    output logic sfs_out
);
    int dump_wait = 3;
    int div = 0;
    logic framed = 1'b0;
    initial begin
        trig_out = 1'b0;
        dump_out = 1'b0;
        sclk_out = 1'b0;
        sfs_out = 1'b0;
    end
    // Two cycles high survives an unsynchronised sampler
    task automatic fire(input int hi);
        @(posedge clk_in);
        #1 trig_out = 1'b1;
        repeat (hi) @(posedge clk_in);
        #1 trig_out = 1'b0;
    endtask
    always begin
        @(posedge full_in);
        repeat (dump_wait) @(posedge clk_in);
        #1 dump_out = 1'b1;
        @(posedge empty_in);
        @(posedge clk_in);
        #1 dump_out = 1'b0;
    end
    // Follower clock stands still outside a readout
    always @(posedge clk_in) begin
        #1;
        if (follow_in && dump_out) begin
            div = (div + 1) % 8;
            // Starts low so the first rise falls after dump is taken
            sclk_out = (div >= 4);
            sfs_out = !framed;
            framed = framed | (div == 7);
        end else begin
            div = 0;
            sclk_out = 1'b0;
            sfs_out = 1'b0;
            framed = 1'b0;
        end
    end
endmodule

// >>> bench/cfr_top_bench.sv
`timescale 1ns/1ps
module cfr_top_bench;
    import cfr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [DW-1:0] smp = 12'h000;
    logic [7:0] code = 8'h00;
    logic [1:0] mode = 2'h0;
    logic [1:0] sel = 2'h0;
    logic [5:0] ratio = 6'h08;
    logic lead = 1'b0;
    logic trig, dump, h_sclk, h_sfs, sclk_w, sfs_w;
    logic full, empty, pclk, dclk, sclk, sclk_oe, sfs, sfs_oe, sdat;
    logic [DW-1:0] pbus;
    logic [HW-1:0] ddat;
    logic [DW-1:0] s_first, s_cont;
    logic [DW-1:0] qp[$];
    logic [HW-1:0] qu[$];
    logic [HW-1:0] ql[$];
    logic qb[$];
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    int t_trig, t_ef, t_fr, t_dump, t_p1, t_pl, t_er, per, sper, s_pl;
    int fs_len, np, nd, ns;

    assign sclk_w = sclk_oe ? sclk : h_sclk;
    assign sfs_w = sfs_oe ? sfs : h_sfs;
    initial forever #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge clk) #1 smp = smp + 12'h001;

    cfr_top i_dut (
        .core_clk_in(clk), .rst_in(rst), .sample_in(smp),
        .fill_trig_in(trig), .dump_req_in(dump),
        .capture_length_code_in(code), .fill_mode_in(mode),
        .out_sel_in(sel), .decim_ratio_in(ratio),
        .serial_leader_in(lead), .serial_port_clock_in(sclk_w),
        .serial_frame_sync_in(sfs_w), .full_out(full),
        .empty_out(empty), .parallel_word_bus_out(pbus),
        .parallel_clk_out(pclk), .ddr_data_out(ddat),
        .ddr_clk_out(dclk), .serial_port_clock_out(sclk),
        .serial_port_clock_oe_out(sclk_oe),
        .serial_frame_sync_out(sfs),
        .serial_frame_sync_oe_out(sfs_oe), .serial_data_out(sdat)
    );
    cfr_host i_host (
        .clk_in(clk), .full_in(full), .empty_in(empty),
        .follow_in(sel == SEL_SER && !lead), .trig_out(trig),
        .dump_out(dump), .sclk_out(h_sclk), .sfs_out(h_sfs)
    );

    task automatic complete_run();
        $display("Compares %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Sampled 2 ns after each edge, once all drives have landed
    task automatic watch(input int lim);
        logic tp, ep, fp, dp, wp, sp, w, on;
        {tp, ep, fp, dp, wp, sp, on} = {trig, empty, full, dump, 3'h0};
        t_ef = 0;
        t_fr = 0;
        t_dump = 0;
        t_p1 = 0;
        t_pl = 0;
        t_er = 0;
        for (int k = 0; k < lim; k++) begin
            @(posedge clk);
            #2;
            w = pclk | dclk;
            if (trig) begin
                t_trig = cyc + 1;
                s_cont = smp;
            end else if (tp) begin
                s_first = smp;
            end
            if (ep && !empty) t_ef = cyc;
            if (!fp && full) t_fr = cyc;
            if (dump && !dp) t_dump = cyc + 1;
            if (w && !wp) begin
                per = cyc - t_pl;
                if (t_p1 == 0) t_p1 = cyc;
                t_pl = cyc;
                qp.push_back(pbus);
                ql.push_back(ddat);
            end
            // Upper half launches at the fall, lower half at the rise
            if (!w && wp) qu.push_back(ddat);
            if (sclk_w && !sp) begin
                sper = cyc - s_pl;
                s_pl = cyc;
                if (on) qb.push_back(sdat);
                on = on | sfs_w;
            end
            fs_len += sfs & sfs_oe;
            np += pclk;
            nd += dclk;
            ns += sclk & sclk_oe;
            if (!ep && empty && t_dump > 0) t_er = cyc;
            {tp, ep, fp, dp, wp, sp} = {trig, empty, full, dump, w, sclk_w};
            if (t_er > 0 && cyc > t_er + 16) return;
        end
        chk("readout end", 1, 0);
        complete_run();
    endtask

    task automatic cap(input logic [1:0] s, input logic [1:0] m,
                       input logic [5:0] r, input logic l,
                       input logic [7:0] c, input int re);
        qp.delete();
        qu.delete();
        ql.delete();
        qb.delete();
        fs_len = 0;
        np = 0;
        nd = 0;
        ns = 0;
        @(posedge clk);
        #1;
        {sel, mode, ratio, lead, code} = {s, m, r, l, c};
        fork
            watch(12000);
            begin
                repeat (m == MODE_CONT ? 300 : 2) @(posedge clk);
                i_host.fire(m == MODE_CONT ? 1 : 2);
                if (re > 0) begin
                    repeat (re) @(posedge clk);
                    i_host.fire(2);
                end
                mode = 2'h0;
            end
        join
    endtask

    task automatic timing_ok(input int n, input int r);
        chk("empty fall delay", 24, t_ef - t_trig);
        chk("full rise delay", n + 13, t_fr - t_trig);
        chk("clock start", 1, t_p1 - t_dump inside {[71:75]});
        chk("clock period", r, per);
        chk("empty rise delay", 9, t_er - t_pl);
        chk("clock parked", 1, t_pl < t_er && !pclk && !dclk);
        chk("one port", 0, ns + (sel == SEL_PAR ? nd : np));
    endtask

    task automatic words_ok(input logic [DW-1:0] s0, input int n);
        int i;
        logic [DW-1:0] nx;
        i = 0;
        while (i < qp.size() && qp[i] !== s0) i++;
        chk("first word slot", 1, i >= 2 && i <= 3);
        chk("word count", n, qp.size() - i);
        for (int k = i; k + 1 < qp.size(); k++) begin
            nx = qp[k] + 12'h001;
            chk("word order", nx, qp[k + 1]);
        end
    endtask

    task automatic ddr_ok();
        int j;
        logic [DW-1:0] nx;
        j = 0;
        while (j + 2 < ql.size() && {qu[j], ql[j + 1]} !== s_first) j++;
        nx = s_first + 12'h001;
        chk("ddr word", s_first, {qu[j], ql[j + 1]});
        chk("ddr next", nx, {qu[j + 1], ql[j + 2]});
        chk("ddr count", 64, ql.size() - j - 1);
    endtask

    task automatic ser_ok(input int off);
        logic [DW-1:0] got;
        for (int k = 0; k < DW; k++) got[DW - 1 - k] = qb[k + off];
        chk("serial word", s_first, got);
        chk("serial only", 0, np + nd);
        chk("pins driven", lead, sclk_oe);
        chk("sync driven", lead, sfs_oe);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        chk("full at reset", 0, full);
        chk("empty at reset", 1, empty);
        chk("clock oe at reset", 0, sclk_oe);
        cap(SEL_PAR, 2'h0, 6'h08, 1'b0, 8'h00, 10);
        timing_ok(64, 8);
        words_ok(s_first, 64);
        cap(SEL_PAR, 2'h0, 6'h08, 1'b0, 8'h01, 0);
        timing_ok(128, 8);
        words_ok(s_first, 128);
        i_host.dump_wait = 40;
        cap(SEL_DDR, 2'h0, 6'h20, 1'b0, 8'h00, 0);
        timing_ok(64, 32);
        ddr_ok();
        i_host.dump_wait = 0;
        cap(SEL_PAR, MODE_CONT, 6'h08, 1'b0, 8'h00, 0);
        words_ok(s_cont - 12'h03f, 64);
        cap(SEL_SER, 2'h0, 6'h08, 1'b1, 8'h00, 0);
        ser_ok(0);
        chk("sync length", sper, fs_len);
        cap(SEL_SER, 2'h0, 6'h08, 1'b0, 8'h00, 0);
        ser_ok(1);
        complete_run();
    end
endmodule
